// file: hw/clpc_ctrl.sv
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
module clpc_ctrl
  import clpc_pkg::*;
#(
  parameter int                            NUM_CORES     = 3,
  parameter logic [7:0][CLPC_CNT_W-1:0]    SLEEP_CYCLES  = CLPC_SLEEP_CYCLES,
  parameter logic [3:0][CLPC_CNT_W-1:0]    SETTLE_CYCLES = CLPC_SETTLE_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wr_data,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  output logic      [7:0]           rd_data,
  input  wire logic                 trigger_input_pin,
  input  wire logic                 foreground_complete_flag,
  input  wire logic                 background_stopped_flag,
  input  wire logic                 fault_flag,
  input  wire logic                 core_cal_done,
  output logic                      status_output_pin,
  output logic                      calibration_trigger,
  output logic      [NUM_CORES-1:0] core_sleep,
  output logic      [NUM_CORES-1:0] core_cal_req,
  output logic                      irq
);

  localparam int CW = (NUM_CORES > 1) ? $clog2(NUM_CORES) : 1;

  typedef struct packed {
    logic [7:0]           pin_cfg;
    logic [7:0]           soft_trig;
    logic [7:0]           lowpower;
    logic [7:0]           ctrl;
    logic [7:0]           irq_stat;
    logic [7:0]           irq_mask;
    logic [7:0]           rd_data;
    logic [2:0]           trig_sync;
    logic                 trig_stable;
    logic [2:0]           flag_prev;
    clpc_phase_t          phase;
    logic [CW-1:0]        core;
    logic [NUM_CORES-1:0] sleep;
    logic [NUM_CORES-1:0] cal_req;
    logic                 stat_pin;
    logic                 trig_out;
    logic                 irq;
  } clpc_state_t;

  clpc_state_t st;
  clpc_state_t next_st;

  logic                  lp_active;
  logic                  trig_sel;
  logic                  trig_mode;
  logic [CW-1:0]         core_after;
  logic [7:0]            events;
  logic [7:0]            irq_clear;
  logic [CLPC_CNT_W-1:0] sleep_cnt;
  logic [CLPC_CNT_W-1:0] settle_cnt;

  clpc_timer_if #(.W(CLPC_CNT_W)) tif ();

  clpc_timer #(.W(CLPC_CNT_W)) u_timer (
    .clk (clk),
    .rst (rst),
    .t   (tif.tmr)
  );

  function automatic logic [NUM_CORES-1:0] core_bit(input logic [CW-1:0] i);
    logic [NUM_CORES-1:0] b;
    b    = '0;
    b[i] = 1'b1;
    return b;
  endfunction

  always_comb
  begin
    next_st    = st;
    lp_active  = st.lowpower[CLPC_LOWPOWER_ENABLE_BIT] & st.ctrl[CLPC_BG_EN_BIT];
    trig_mode  = st.lowpower[CLPC_LOWPOWER_TRIGGER_MODE_BIT];
    trig_sel   = st.pin_cfg[CLPC_TRIG_SRC_BIT]
               ? st.trig_stable
               : st.soft_trig[CLPC_SOFT_TRIG_BIT];
    sleep_cnt  = SLEEP_CYCLES[st.lowpower[CLPC_SLEEP_CODE_LSB +: 3]];
    settle_cnt = SETTLE_CYCLES[st.lowpower[CLPC_WAKE_CODE_LSB +: 2]];
    core_after = (st.core == CW'(NUM_CORES - 1)) ? '0 : st.core + CW'(1);
    tif.load   = 1'b0;
    tif.value  = '0;
    events     = '0;
    irq_clear  = '0;

    // The first stage feeds only the second; the pin level is taken once
    // the second and third stages agree, which filters a metastable edge.
    next_st.trig_sync = {st.trig_sync[1:0], trigger_input_pin};
    if (st.trig_sync[1] == st.trig_sync[2])
    begin
      next_st.trig_stable = st.trig_sync[2];
    end
    next_st.trig_out = trig_sel;

    unique case (st.pin_cfg[CLPC_STAT_SEL_LSB +: 2])
      CLPC_STAT_FG:    next_st.stat_pin = foreground_complete_flag;
      CLPC_STAT_STOP:  next_st.stat_pin = background_stopped_flag;
      CLPC_STAT_FAULT: next_st.stat_pin = fault_flag;
      CLPC_STAT_LOW:   next_st.stat_pin = 1'b0;
    endcase

    next_st.rd_data = CLPC_READ_IDLE;
    if (rd_en)
    begin
      unique case (addr)
        CLPC_ADDR_PIN_CFG:   next_st.rd_data = st.pin_cfg;
        CLPC_ADDR_SOFT_TRIG: next_st.rd_data = st.soft_trig;
        CLPC_ADDR_LOWPOWER:  next_st.rd_data = st.lowpower;
        CLPC_ADDR_IRQ_STAT:  next_st.rd_data = st.irq_stat;
        CLPC_ADDR_IRQ_MASK:  next_st.rd_data = st.irq_mask;
        CLPC_ADDR_CTRL:      next_st.rd_data = st.ctrl;
        CLPC_ADDR_STATE:     next_st.rd_data = {lp_active, trig_sel, 1'b0,
                                                st.phase};
        default:             next_st.rd_data = CLPC_READ_IDLE;
      endcase
    end

    if (wr_en)
    begin
      unique case (addr)
        CLPC_ADDR_PIN_CFG:   next_st.pin_cfg   = wr_data;
        CLPC_ADDR_SOFT_TRIG: next_st.soft_trig = wr_data;
        CLPC_ADDR_LOWPOWER:  next_st.lowpower  = wr_data;
        CLPC_ADDR_IRQ_STAT:  irq_clear         = wr_data;
        CLPC_ADDR_IRQ_MASK:  next_st.irq_mask  = wr_data;
        CLPC_ADDR_CTRL:      next_st.ctrl      = wr_data;
        default:             next_st.ctrl      = st.ctrl;
      endcase
    end

    // Low-power phase sequence for one core at a time.
    unique case (st.phase)
      CLPC_IDLE:
      begin
        if (lp_active)
        begin
          next_st.phase = CLPC_SLEEP;
          next_st.sleep = core_bit(st.core);
          tif.load      = 1'b1;
          tif.value     = sleep_cnt;
        end
      end
      CLPC_SLEEP:
      begin
        // The timer is loaded in both modes so a switch to timed mode
        // during a long sleep still ends it.
        if (trig_mode ? !trig_sel : tif.idle)
        begin
          next_st.phase = CLPC_WAKE;
          next_st.sleep = '0;
        end
      end
      CLPC_WAKE:
      begin
        next_st.phase = CLPC_SETTLE;
        tif.load      = 1'b1;
        tif.value     = settle_cnt;
      end
      CLPC_SETTLE:
      begin
        if (tif.idle)
        begin
          next_st.phase   = CLPC_CAL;
          next_st.cal_req = core_bit(st.core);
        end
      end
      CLPC_CAL:
      begin
        if (core_cal_done)
        begin
          next_st.phase   = CLPC_SLEEP;
          next_st.cal_req = '0;
          next_st.core    = core_after;
          next_st.sleep   = core_bit(core_after);
          events[CLPC_EV_CORE_BIT] = 1'b1;
          tif.load        = 1'b1;
          tif.value       = sleep_cnt;
        end
      end
    endcase

    if (!lp_active)
    begin
      next_st.phase   = CLPC_IDLE;
      next_st.sleep   = '0;
      next_st.cal_req = '0;
      tif.load        = 1'b1;
      tif.value       = '0;
    end

    next_st.flag_prev = {fault_flag, background_stopped_flag,
                         foreground_complete_flag};
    events[CLPC_EV_FG_BIT]    = foreground_complete_flag & ~st.flag_prev[0];
    events[CLPC_EV_STOP_BIT]  = background_stopped_flag & ~st.flag_prev[1];
    events[CLPC_EV_FAULT_BIT] = fault_flag & ~st.flag_prev[2];
    // A new event beats a clear written in the same cycle.
    next_st.irq_stat = (st.irq_stat & ~irq_clear) | events;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st           <= '0;
      st.pin_cfg   <= CLPC_PIN_CFG_RESET;
      st.soft_trig <= CLPC_SOFT_TRIG_RESET;
      st.lowpower  <= CLPC_LOWPOWER_RESET;
      st.ctrl      <= CLPC_CTRL_RESET;
      st.irq_mask  <= CLPC_IRQ_MASK_RESET;
      st.phase     <= CLPC_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data             = st.rd_data;
  assign status_output_pin   = st.stat_pin;
  assign calibration_trigger = st.trig_out;
  assign core_sleep          = st.sleep;
  assign core_cal_req        = st.cal_req;
  assign irq                 = st.irq;

  default clocking clpc_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  stat_low_a: assert property (
    st.pin_cfg[2:1] == CLPC_STAT_LOW |=> !status_output_pin)
    else $error("status pin not low for select code 3");

  stat_fg_a: assert property (
    st.pin_cfg[2:1] == CLPC_STAT_FG
      |=> status_output_pin == $past(foreground_complete_flag))
    else $error("status pin does not follow foreground flag");

  stat_stop_a: assert property (
    st.pin_cfg[2:1] == CLPC_STAT_STOP
      |=> status_output_pin == $past(background_stopped_flag))
    else $error("status pin does not follow stopped flag");

  soft_src_a: assert property (
    !st.pin_cfg[0] |=> calibration_trigger == $past(st.soft_trig[0]))
    else $error("software trigger not selected");

  pin_src_a: assert property (
    st.pin_cfg[0] && trigger_input_pin ##1 trigger_input_pin [*3]
      ##1 st.pin_cfg[0] [*2] |=> calibration_trigger)
    else $error("trigger pin level not passed through");

  lp_reset_a: assert property (
    $past(rst) |-> st.lowpower == 8'h88 && st.soft_trig == 8'h01)
    else $error("low power register reset value wrong");

  sleep_load_a: assert property (
    st.phase != CLPC_SLEEP && next_st.phase == CLPC_SLEEP
      |-> tif.load && tif.value == SLEEP_CYCLES[st.lowpower[7:5]])
    else $error("sleep interval loaded wrong");

  settle_seq_a: assert property (
    st.phase == CLPC_WAKE && lp_active
      |=> st.phase == CLPC_SETTLE && !tif.idle && core_sleep == '0)
    else $error("settle interval not started after wake");

  trig_hold_a: assert property (
    st.phase == CLPC_SLEEP && trig_mode && trig_sel && lp_active
      |=> st.phase == CLPC_SLEEP && core_sleep != '0)
    else $error("core woke while trigger high");

  cal_req_a: assert property (
    st.phase == CLPC_SETTLE && tif.idle && lp_active
      |=> st.phase == CLPC_CAL && core_cal_req != '0)
    else $error("calibration not requested after settle");

  lp_gate_a: assert property (
    !st.ctrl[0] |=> st.phase == CLPC_IDLE && core_sleep == '0)
    else $error("low power running without background enable");

  irq_out_a: assert property (
    |(st.irq_stat & st.irq_mask) && !wr_en |=> irq)
    else $error("interrupt not raised for unmasked status");

endmodule

// file: hw/clpc_pkg.sv
package clpc_pkg;

  // Register offsets on the 8-bit register port.
  localparam logic [7:0] CLPC_ADDR_PIN_CFG   = 8'h6B;
  localparam logic [7:0] CLPC_ADDR_SOFT_TRIG = 8'h6C;
  localparam logic [7:0] CLPC_ADDR_LOWPOWER  = 8'h6E;
  localparam logic [7:0] CLPC_ADDR_IRQ_STAT  = 8'hF0;
  localparam logic [7:0] CLPC_ADDR_IRQ_MASK  = 8'hF1;
  localparam logic [7:0] CLPC_ADDR_CTRL      = 8'hF2;
  localparam logic [7:0] CLPC_ADDR_STATE     = 8'hF3;

  // Values after reset.
  localparam logic [7:0] CLPC_PIN_CFG_RESET   = 8'h00;
  localparam logic [7:0] CLPC_SOFT_TRIG_RESET = 8'h01;
  localparam logic [7:0] CLPC_LOWPOWER_RESET  = 8'h88;
  localparam logic [7:0] CLPC_CTRL_RESET      = 8'h00;
  localparam logic [7:0] CLPC_IRQ_MASK_RESET  = 8'h00;
  localparam logic [7:0] CLPC_READ_IDLE       = 8'h00;

  // Field positions.
  localparam int CLPC_TRIG_SRC_BIT   = 0;
  localparam int CLPC_STAT_SEL_LSB   = 1;
  localparam int CLPC_SOFT_TRIG_BIT  = 0;
  localparam int CLPC_LOWPOWER_ENABLE_BIT      = 0;
  localparam int CLPC_LOWPOWER_TRIGGER_MODE_BIT    = 1;
  localparam int CLPC_WAKE_CODE_LSB  = 3;
  localparam int CLPC_SLEEP_CODE_LSB = 5;
  localparam int CLPC_BG_EN_BIT      = 0;
  localparam int CLPC_EV_FG_BIT      = 0;
  localparam int CLPC_EV_STOP_BIT    = 1;
  localparam int CLPC_EV_FAULT_BIT   = 2;
  localparam int CLPC_EV_CORE_BIT    = 3;

  // Status pin source codes.
  localparam logic [1:0] CLPC_STAT_FG    = 2'h0;
  localparam logic [1:0] CLPC_STAT_STOP  = 2'h1;
  localparam logic [1:0] CLPC_STAT_FAULT = 2'h2;
  localparam logic [1:0] CLPC_STAT_LOW   = 2'h3;

  // Delays are (2^k + 1) * 256 clock periods; counter wide enough for k=33.
  localparam int CLPC_CNT_W     = 44;
  localparam int CLPC_DLY_SHIFT = 8;

  function automatic logic [CLPC_CNT_W-1:0] clpc_dly_cycles(
    input int unsigned e
  );
    return ((CLPC_CNT_W'(1) << e) + CLPC_CNT_W'(1)) << CLPC_DLY_SHIFT;
  endfunction

  localparam logic [7:0][CLPC_CNT_W-1:0] CLPC_SLEEP_CYCLES = '{
    clpc_dly_cycles(33), clpc_dly_cycles(30), clpc_dly_cycles(27),
    clpc_dly_cycles(24), clpc_dly_cycles(21), clpc_dly_cycles(18),
    clpc_dly_cycles(15), clpc_dly_cycles(3)};

  localparam logic [3:0][CLPC_CNT_W-1:0] CLPC_SETTLE_CYCLES = '{
    clpc_dly_cycles(24), clpc_dly_cycles(21), clpc_dly_cycles(18),
    clpc_dly_cycles(3)};

  typedef enum logic [4:0] {
    CLPC_IDLE   = 5'h01,
    CLPC_SLEEP  = 5'h02,
    CLPC_WAKE   = 5'h04,
    CLPC_SETTLE = 5'h08,
    CLPC_CAL    = 5'h10
  } clpc_phase_t;

endpackage

// file: hw/clpc_timer_if.sv
`timescale 1ns/100ps
interface clpc_timer_if #(parameter int W = 44);
  logic         load;
  logic [W-1:0] value;
  logic         idle;
  modport ctrl (output load, output value, input idle);
  modport tmr  (input load, input value, output idle);
endinterface

// file: hw/clpc_timer.sv
`timescale 1ns/100ps
module clpc_timer #(
  parameter int W = 44
) (
  input wire logic clk,
  input wire logic rst,
  clpc_timer_if.tmr t
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } clpc_tmr_state_t;

  clpc_tmr_state_t st;
  clpc_tmr_state_t next_st;

  // Idle is combinational so the owner sees expiry in the same cycle.
  assign t.idle = (st.cnt == '0);

  always_comb
  begin
    next_st = st;
    if (t.load)
    begin
      next_st.cnt = t.value;
    end
    else if (st.cnt != '0)
    begin
      next_st.cnt = st.cnt - W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

// file: verif/clpc_host_model.sv
`timescale 1ns/100ps
module clpc_host_model (
  input  wire logic clk,
  input  wire logic drive_level,
  input  wire logic status_output_pin,
  output logic      trigger_input_pin = 1'b0,
  output logic      status_seen = 1'b0
);
  // The host launches the trigger from its own flop and samples the status
  // pin one edge late, as a separate logic device on the board would.
  always @(posedge clk)
  begin
    trigger_input_pin <= drive_level;
    status_seen       <= status_output_pin;
  end
endmodule

// file: verif/calibration_trigger_lowpower_ctrl_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module calibration_trigger_lowpower_ctrl_tb_top
  import clpc_pkg::*;
;
  // Shortened delays keep every code reachable in a few thousand cycles.
  localparam logic [7:0][CLPC_CNT_W-1:0] SLP = '{44'h10, 44'hF, 44'hE,
    44'hD, 44'hC, 44'hB, 44'hA, 44'h9};
  localparam logic [3:0][CLPC_CNT_W-1:0] STL = '{44'h14, 44'hA, 44'h8, 44'h6};
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] rd_data;
  logic       pin_level = 1'b0;
  logic       fg = 1'b0;
  logic       stop = 1'b0;
  logic       fault = 1'b0;
  logic       cal_done = 1'b0;
  logic       trig_pin;
  logic       status_pin;
  logic       status_seen;
  logic       cal_trig;
  logic       irq;
  logic [2:0] core_sleep;
  logic [2:0] cal_req;
  logic       e;
  int         error_cnt = 0;
  int         comparisons = 0;

  clpc_host_model host (
    .clk               (clk),
    .drive_level       (pin_level),
    .status_output_pin (status_pin),
    .trigger_input_pin (trig_pin),
    .status_seen       (status_seen)
  );

  clpc_ctrl #(
    .NUM_CORES     (3),
    .SLEEP_CYCLES  (SLP),
    .SETTLE_CYCLES (STL)
  ) dut (
    .clk                      (clk),
    .rst                      (rst),
    .addr                     (addr),
    .wr_data                  (wr_data),
    .wr_en                    (wr_en),
    .rd_en                    (rd_en),
    .rd_data                  (rd_data),
    .trigger_input_pin        (trig_pin),
    .foreground_complete_flag (fg),
    .background_stopped_flag  (stop),
    .fault_flag               (fault),
    .core_cal_done            (cal_done),
    .status_output_pin        (status_pin),
    .calibration_trigger      (cal_trig),
    .core_sleep               (core_sleep),
    .core_cal_req             (cal_req),
    .irq                      (irq)
  );

  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rd_data, x)
  endtask

  task automatic done(input string s);
    $display("Test %s finished, %0d mismatches so far", s, error_cnt);
  endtask

  // The core pointer is kept across a disable, so k names the core that
  // sleeps first in this run.
  task automatic lp_run(input int c, input int w, input logic [2:0] k);
    int n;
    wr(CLPC_ADDR_LOWPOWER, {c[2:0], w[1:0], 3'b001});
    n = 0;
    step(1);
    while (core_sleep !== k && n < 20)
    begin
      step(1);
      n++;
    end
    `CHK(core_sleep, k)
    n = 0;
    while (core_sleep === k && n < 100)
    begin
      step(1);
      n++;
    end
    `CHK(44'(n), SLP[c] + 44'h1)
    n = 0;
    while (cal_req !== k && n < 100)
    begin
      step(1);
      n++;
    end
    `CHK(44'(n), STL[w] + 44'h2)
    @(posedge clk);
    cal_done <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    #1;
    `CHK({core_sleep, cal_req}, {k[1:0], k[2], 3'b000})
    wr(CLPC_ADDR_LOWPOWER, {c[2:0], w[1:0], 3'b000});
    step(2);
    `CHK({core_sleep, cal_req}, 6'h00)
  endtask

  task automatic results;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons,
             error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    results();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdchk(CLPC_ADDR_PIN_CFG, 8'h00);
    rdchk(CLPC_ADDR_SOFT_TRIG, 8'h01);
    rdchk(CLPC_ADDR_LOWPOWER, 8'h88);
    rdchk(CLPC_ADDR_IRQ_STAT, 8'h00);
    rdchk(CLPC_ADDR_IRQ_MASK, 8'h00);
    rdchk(CLPC_ADDR_CTRL, 8'h00);
    rdchk(8'h10, 8'h00);
    rdchk(CLPC_ADDR_STATE, 8'h41);
    `CHK(cal_trig, 1'b1)
    `CHK(CLPC_SLEEP_CYCLES[7], 44'h200_0000_0100)
    `CHK(CLPC_SETTLE_CYCLES[1], 44'h000_0400_0100)
    done("reset");
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk);
      fg    <= ~p[0];
      stop  <= p[0];
      fault <= ~p[0];
      for (int c = 0; c < 4; c++)
      begin
        wr(CLPC_ADDR_PIN_CFG, {5'h00, c[1:0], 1'b0});
        step(4);
        e = (c == 0) ? fg : (c == 1) ? stop : (c == 2) ? fault : 1'b0;
        `CHK(status_seen, e)
      end
    end
    done("status select");
    @(posedge clk);
    pin_level <= 1'b1;
    wr(CLPC_ADDR_SOFT_TRIG, 8'h00);
    step(8);
    `CHK(cal_trig, 1'b0)
    wr(CLPC_ADDR_PIN_CFG, 8'h01);
    step(8);
    `CHK(cal_trig, 1'b1)
    @(posedge clk);
    pin_level <= 1'b0;
    wr(CLPC_ADDR_SOFT_TRIG, 8'h01);
    step(8);
    `CHK(cal_trig, 1'b0)
    wr(CLPC_ADDR_PIN_CFG, 8'h00);
    step(3);
    `CHK(cal_trig, 1'b1)
    done("trigger source");
    wr(CLPC_ADDR_LOWPOWER, 8'h89);
    step(30);
    `CHK(core_sleep, 3'b000)
    wr(CLPC_ADDR_CTRL, 8'h01);
    step(2);
    `CHK(core_sleep, 3'b001)
    wr(CLPC_ADDR_LOWPOWER, 8'h88);
    // All eight sleep codes are run on purpose; each run also checks settle timing and the hand-over to the next core.
    for (int c = 0; c < 8; c++)
      lp_run(c, c % 4, 3'b001 << (c % 3));
    // Eight finished cores leave the round robin pointing at core 2.
    wr(CLPC_ADDR_LOWPOWER, 8'h8B);
    step(40);
    `CHK(core_sleep, 3'b100)
    wr(CLPC_ADDR_SOFT_TRIG, 8'h00);
    step(4);
    `CHK(core_sleep, 3'b000)
    wr(CLPC_ADDR_LOWPOWER, 8'h88);
    wr(CLPC_ADDR_SOFT_TRIG, 8'h01);
    done("low power");
    rdchk(CLPC_ADDR_IRQ_STAT, 8'h0F);
    `CHK(irq, 1'b0)
    wr(CLPC_ADDR_IRQ_MASK, 8'h04);
    step(2);
    `CHK(irq, 1'b1)
    wr(CLPC_ADDR_IRQ_STAT, 8'h04);
    step(2);
    `CHK(irq, 1'b0)
    rdchk(CLPC_ADDR_IRQ_STAT, 8'h0B);
    done("interrupt");
    results();
  end
endmodule
